// file: design/sac_params.svh
// constants of the successive-approximation conversion controller
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// =====================================================================
// converter geometry
`define SAC_RES_BITS 10
`define SAC_HI_BITS 8
`define SAC_LO_BITS 2

// =====================================================================
// timing, in their own units
`define SAC_CLK_MHZ 250
`define SAC_T_CS_NS 500
`define SAC_T_DSC_NS 1500
`define SAC_T_STEP_NS 2000
`define SAC_T_CONV_MAX_NS 30000

// =====================================================================
// apb byte addresses
`define SAC_ADDR_W 12
`define SAC_ADDR_CTRL 12'h000
`define SAC_ADDR_STATUS 12'h004
`define SAC_ADDR_RESULT 12'h008
`define SAC_ADDR_INT_STAT 12'h00C
`define SAC_ADDR_INT_MASK 12'h010

// =====================================================================
// field positions
`define SAC_CTRL_START 0
`define SAC_STAT_BUSY 0
`define SAC_STAT_VALID 1
`define SAC_STAT_UNIPOLAR 2
`define SAC_INT_DONE 0
`define SAC_INT_ABORT 1
`define SAC_INT_W 2

// =====================================================================
// reset values
`define SAC_INT_MASK_RST 2'h0
// enables released and range unipolar, so no offset pulse after reset
`define SAC_SYNC_RST 5'h07
`define SAC_SYNC_W 5

`endif

// file: design/sac_pkg.sv
// types shared by the conversion controller modules
package sac_pkg;

   // ==================================================================
   // sequencer states
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_hold = 2'b01,
      st_run = 2'b10
   } sac_state_type;

endpackage : sac_pkg

// file: design/sac_sar_if.sv
// link between the sequencer and the approximation register core
`timescale 1ns/1ns

interface sac_sar_if #(
   parameter int W = 10
) ();
   logic rst_n; // synchronised reset, active low
   logic ce; // clock enable
   logic clear; // wipe result, stop trial
   logic go; // start trial at msb
   logic sample; // take one comparator decision
   logic comp_gt; // dac sum above input
   logic [W-1:0] code; // register contents, partial or final
   logic busy; // trial in progress
   logic finish; // one-cycle pulse after lsb decided

   modport ctrl (
      output rst_n, ce, clear, go, sample, comp_gt,
      input code, busy, finish
   );
   modport core (
      input rst_n, ce, clear, go, sample, comp_gt,
      output code, busy, finish
   );
endinterface : sac_sar_if

// file: design/sac_sar_core.sv
// successive approximation register, one decision per sample strobe
`timescale 1ns/1ns

module sac_sar_core #(
   parameter int W = 10
) (
   // clock
   input wire logic ref_clk,
   // sequencer side
   sac_sar_if.core sif
);

   localparam int IW = $clog2(W);
   localparam logic [IW-1:0] TOP_IDX = IW'(W - 1);
   localparam logic [IW-1:0] IDX_ZERO = '0;

   logic [W-1:0] code_ff; // trial and decided bits
   logic [IW-1:0] idx_ff; // bit now under trial
   logic busy_ff; // sequence running
   logic finish_ff; // end-of-conversion pulse

   // ==================================================================
   // approximation register
   // clear has top priority so a new start always aborts cleanly
   always_ff @(posedge ref_clk or negedge sif.rst_n) begin
      if (!sif.rst_n) begin
         code_ff <= '0;
         idx_ff <= '0;
         busy_ff <= 1'b0;
         finish_ff <= 1'b0;
      end else if (sif.ce) begin
         finish_ff <= 1'b0;
         if (sif.clear) begin
            // wipe the previous result on the start edge
            code_ff <= '0;
            idx_ff <= TOP_IDX;
            busy_ff <= 1'b0;
         end else if (sif.go) begin
            code_ff <= '0;
            code_ff[TOP_IDX] <= 1'b1;
            idx_ff <= TOP_IDX;
            busy_ff <= 1'b1;
         end else if (sif.sample && busy_ff) begin
            // drop bit when sum exceeds input
            if (sif.comp_gt) begin
               code_ff[idx_ff] <= 1'b0;
            end
            if (idx_ff == IDX_ZERO) begin
               // final code now held until next start
               busy_ff <= 1'b0;
               finish_ff <= 1'b1;
            end else begin
               code_ff[idx_ff - 1'b1] <= 1'b1;
               idx_ff <= idx_ff - 1'b1;
            end
         end
      end
   end

   assign sif.code = code_ff;
   assign sif.busy = busy_ff;
   assign sif.finish = finish_ff;

endmodule : sac_sar_core

// file: design/sac_adc_ctrl.sv
// top of the successive-approximation conversion controller
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "sac_params.svh"

module sac_adc_ctrl #(
   parameter int W = `SAC_RES_BITS,
   parameter int STEP_CYC = (`SAC_T_STEP_NS * `SAC_CLK_MHZ + 999) / 1000,
   parameter int CS_CYC = (`SAC_T_CS_NS * `SAC_CLK_MHZ + 999) / 1000
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SAC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter pins
   input wire logic convert,
   input wire logic range_unipolar,
   input wire logic upper_byte_output_enable_n,
   input wire logic lower_byte_output_enable_n,
   output logic conversion_done_n,
   output logic [`SAC_HI_BITS-1:0] data_hi_o,
   output logic data_hi_oe,
   output logic [`SAC_LO_BITS-1:0] data_lo_o,
   output logic data_lo_oe,
   // analog front end
   input wire logic comp_gt,
   output logic [W-1:0] dac_code,
   output logic offset_inject,
   // interrupt
   output logic irq
);

   // ==================================================================
   // derived counts
   localparam int SW = $clog2(STEP_CYC + 1);
   localparam int CW = $clog2(CS_CYC + 1);
   localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYC - 1);
   localparam logic [CW-1:0] CS_LAST = CW'(CS_CYC - 1);
   localparam logic [CW-1:0] CS_ZERO = '0;
   // done line reaction bound, kept for reference by integrators
   localparam int DSC_CYC = (`SAC_T_DSC_NS * `SAC_CLK_MHZ) / 1000;

   // ==================================================================
   // reset release
   logic rst_s1_ff; // first stage, read only by second
   logic rst_n_ff; // synchronised reset used everywhere

   // two flops so release never lands near a clock edge
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n_ff <= rst_s1_ff;
      end
   end

   // ==================================================================
   // pin synchronisers
   logic [`SAC_SYNC_W-1:0] pin_raw; // raw asynchronous pins
   logic [`SAC_SYNC_W-1:0] pin_s1_ff; // first stage only
   logic [`SAC_SYNC_W-1:0] pin_s2_ff; // safe copy
   logic conv_pin; // synchronised start pin
   logic comp_s; // synchronised comparator
   logic uni_s; // synchronised range select
   logic ube_n_s; // synchronised upper enable
   logic lbe_n_s; // synchronised lower enable

   assign pin_raw = {convert, comp_gt, range_unipolar,
                     upper_byte_output_enable_n,
                     lower_byte_output_enable_n};

   // enables reset to released so buffers start floating
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pin_s1_ff <= `SAC_SYNC_RST;
         pin_s2_ff <= `SAC_SYNC_RST;
      end else if (clk_en) begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   assign {conv_pin, comp_s, uni_s, ube_n_s, lbe_n_s} = pin_s2_ff;

   // ==================================================================
   // software start pulse
   logic sw_conv_ff; // internal start level from software
   logic [CW-1:0] sw_cnt_ff; // remaining width of that level
   logic wr_ctrl; // accepted write to control register

   // stretches a register write into a pulse of full start width
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         sw_conv_ff <= 1'b0;
         sw_cnt_ff <= '0;
      end else if (clk_en) begin
         if (wr_ctrl && pwdata[`SAC_CTRL_START]) begin
            // own start always meets minimum width
            sw_conv_ff <= 1'b1;
            sw_cnt_ff <= CS_LAST;
         end else if (sw_conv_ff) begin
            if (sw_cnt_ff == CS_ZERO) begin
               sw_conv_ff <= 1'b0;
            end else begin
               sw_cnt_ff <= sw_cnt_ff - 1'b1;
            end
         end
      end
   end

   // ==================================================================
   // start edge detection
   logic conv_lvl; // combined start level
   logic conv_prev_ff; // start level one cycle ago
   logic conv_rise; // leading edge
   logic conv_fall; // trailing edge

   assign conv_lvl = conv_pin | sw_conv_ff;
   assign conv_rise = conv_lvl & ~conv_prev_ff;
   assign conv_fall = ~conv_lvl & conv_prev_ff;

   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         conv_prev_ff <= 1'b0;
      end else if (clk_en) begin
         conv_prev_ff <= conv_lvl;
      end
   end

   // ==================================================================
   // sequencer
   sac_sar_if #(.W(W)) sif ();
   sac_pkg::sac_state_type state_ff; // sequencer state
   logic [SW-1:0] step_cnt_ff; // cycles within one bit step
   logic done_n_ff; // active-low done line
   logic ev_done; // conversion finished this cycle
   logic ev_abort; // running conversion cut short

   assign sif.rst_n = rst_n_ff;
   assign sif.ce = clk_en;
   assign sif.clear = conv_rise;
   // trial only after the trailing edge
   assign sif.go = (state_ff == sac_pkg::st_hold) && conv_fall;
   assign sif.sample = (state_ff == sac_pkg::st_run) &&
                       (step_cnt_ff == STEP_LAST);
   assign sif.comp_gt = comp_s;
   assign ev_done = sif.finish;
   // new start during a run aborts it
   assign ev_abort = conv_rise && (state_ff == sac_pkg::st_run);

   sac_sar_core #(.W(W)) u_core (
      .ref_clk(ref_clk),
      .sif(sif.core)
   );

   // state walk: idle -> hold while start high -> run -> idle
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         state_ff <= sac_pkg::st_idle;
      end else if (clk_en) begin
         case (state_ff)
            sac_pkg::st_idle: begin
               if (conv_rise) begin
                  state_ff <= sac_pkg::st_hold;
               end
            end
            sac_pkg::st_hold: begin
               // wait here while start stays high
               if (conv_fall) begin
                  state_ff <= sac_pkg::st_run;
               end
            end
            sac_pkg::st_run: begin
               if (conv_rise) begin
                  state_ff <= sac_pkg::st_hold;
               end else if (ev_done) begin
                  state_ff <= sac_pkg::st_idle;
               end
            end
            default: begin
               state_ff <= sac_pkg::st_idle;
            end
         endcase
      end
   end

   // step timer restarts with every bit so steps are equal length
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         step_cnt_ff <= '0;
      end else if (clk_en) begin
         if (state_ff != sac_pkg::st_run || sif.sample) begin
            step_cnt_ff <= '0;
         end else begin
            step_cnt_ff <= step_cnt_ff + 1'b1;
         end
      end
   end

   // done line high from reset: no result is valid yet
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         done_n_ff <= 1'b1;
      end else if (clk_en) begin
         if (conv_rise) begin
            // raise done line, far inside bound
            done_n_ff <= 1'b1;
         end else if (ev_done) begin
            // lower done line after lsb decision
            done_n_ff <= 1'b0;
         end
      end
   end

   // ==================================================================
   // pin outputs
   logic [`SAC_HI_BITS-1:0] data_hi_ff; // upper byte buffer
   logic data_hi_oe_ff; // upper buffer drive
   logic [`SAC_LO_BITS-1:0] data_lo_ff; // lower bits buffer
   logic data_lo_oe_ff; // lower buffer drive
   logic offset_ff; // bipolar offset switch

   // buffers always follow the register, so early reads see partials
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         data_hi_ff <= '0;
         data_lo_ff <= '0;
         data_hi_oe_ff <= 1'b0;
         data_lo_oe_ff <= 1'b0;
      end else if (clk_en) begin
         data_hi_ff <= sif.code[W-1 -: `SAC_HI_BITS];
         data_lo_ff <= sif.code[`SAC_LO_BITS-1:0];
         data_hi_oe_ff <= ~ube_n_s;
         data_lo_oe_ff <= ~lbe_n_s;
      end
   end

   // range is read live; changing it mid-run corrupts that result
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         offset_ff <= 1'b0;
      end else if (clk_en) begin
         // offset makes midscale the zero code
         offset_ff <= ~uni_s;
      end
   end

   // ==================================================================
   // interrupt status and mask
   logic [`SAC_INT_W-1:0] int_stat_ff; // sticky events
   logic [`SAC_INT_W-1:0] int_mask_ff; // enables per event
   logic [`SAC_INT_W-1:0] int_set; // events this cycle
   logic [`SAC_INT_W-1:0] int_clr; // write-one-to-clear mask
   logic irq_ff; // registered interrupt level
   logic wr_acc; // accepted apb write
   logic acc; // apb access completing

   assign int_set = {ev_abort, ev_done};
   assign int_clr = (wr_acc && paddr == `SAC_ADDR_INT_STAT) ?
                    pwdata[`SAC_INT_W-1:0] : '0;

   // set wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         int_stat_ff <= '0;
         int_mask_ff <= `SAC_INT_MASK_RST;
         irq_ff <= 1'b0;
      end else if (clk_en) begin
         int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
         if (wr_acc && paddr == `SAC_ADDR_INT_MASK) begin
            int_mask_ff <= pwdata[`SAC_INT_W-1:0];
         end
         irq_ff <= |(int_stat_ff & int_mask_ff);
      end
   end

   // ==================================================================
   // apb slave, one wait state per access
   logic pready_ff; // answer strobe
   logic pslverr_ff; // unmapped address
   logic [31:0] prdata_ff; // read data
   logic [31:0] rd_mux; // decoded read value
   logic hit; // address is mapped

   assign acc = psel && penable && pready_ff;
   assign wr_acc = acc && pwrite;
   assign wr_ctrl = wr_acc && (paddr == `SAC_ADDR_CTRL);

   // read decode; start bit is write-only and reads zero
   always_comb begin
      rd_mux = '0;
      hit = 1'b1;
      case (paddr)
         `SAC_ADDR_CTRL: begin
            rd_mux = '0;
         end
         `SAC_ADDR_STATUS: begin
            rd_mux[`SAC_STAT_BUSY] = (state_ff != sac_pkg::st_idle);
            rd_mux[`SAC_STAT_VALID] = ~done_n_ff;
            rd_mux[`SAC_STAT_UNIPOLAR] = uni_s;
         end
         `SAC_ADDR_RESULT: begin
            rd_mux[W-1:0] = sif.code;
         end
         `SAC_ADDR_INT_STAT: begin
            rd_mux[`SAC_INT_W-1:0] = int_stat_ff;
         end
         `SAC_ADDR_INT_MASK: begin
            rd_mux[`SAC_INT_W-1:0] = int_mask_ff;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // ready rises in the second access cycle and drops right after
   always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= '0;
      end else if (clk_en) begin
         pready_ff <= psel && penable && !pready_ff;
         pslverr_ff <= psel && penable && !pready_ff && !hit;
         if (psel && penable && !pready_ff && !pwrite) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   // ==================================================================
   // output wiring, all from flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign conversion_done_n = done_n_ff;
   assign data_hi_o = data_hi_ff;
   assign data_hi_oe = data_hi_oe_ff;
   assign data_lo_o = data_lo_ff;
   assign data_lo_oe = data_lo_oe_ff;
   assign dac_code = sif.code;
   assign offset_inject = offset_ff;
   assign irq = irq_ff;

endmodule : sac_adc_ctrl

// file: test/sac_adc_ctrl_props.sv
// concurrent checks on the conversion controller top ports
`timescale 1ns/1ns
`include "sac_params.svh"

module sac_adc_ctrl_props #(
   parameter int W = 10,
   parameter int STEP_CYC = 500
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // converter pins
   input wire logic convert,
   input wire logic range_unipolar,
   input wire logic upper_byte_output_enable_n,
   input wire logic lower_byte_output_enable_n,
   input wire logic conversion_done_n,
   input wire logic [`SAC_HI_BITS-1:0] data_hi_o,
   input wire logic data_hi_oe,
   input wire logic [`SAC_LO_BITS-1:0] data_lo_o,
   input wire logic data_lo_oe,
   // analog front end
   input wire logic [W-1:0] dac_code,
   input wire logic offset_inject
);
   // =================================================================
   // one domain, so clock and reset are given once
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // cycles since the start pin was last high; saturates, never wraps
   logic [15:0] low_cnt_ff;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         low_cnt_ff <= 16'h0000;
      end else if (convert) begin
         low_cnt_ff <= 16'h0000;
      end else if (low_cnt_ff != 16'hFFFF) begin
         low_cnt_ff <= low_cnt_ff + 16'h0001;
      end
   end
   // =================================================================
   // start, sequencing and result
   AST_DONE_RISE: assert property (
      $rose(convert) |-> ##[1:375] conversion_done_n)
      else $error("done line not raised after start");
   AST_CODE_CLEAR: assert property (
      $rose(convert) |-> ##[1:10] (dac_code == '0))
      else $error("register not cleared by start");
   AST_HOLD_IDLE: assert property (
      convert [*8] |-> (dac_code == '0))
      else $error("trial ran while start held high");
   AST_DONE_LATE: assert property (
      $fell(conversion_done_n) |-> (low_cnt_ff >= 10 * STEP_CYC))
      else $error("done line fell before ten steps");
   AST_DONE_STABLE: assert property (
      !conversion_done_n ##1 !conversion_done_n |-> $stable(dac_code))
      else $error("result moved while valid");
   // =================================================================
   // output buffers and range
   AST_HI_DATA: assert property (
      data_hi_oe |-> (data_hi_o == $past(dac_code[W-1:2])))
      else $error("upper pins not upper result bits");
   AST_LO_DATA: assert property (
      data_lo_oe |-> (data_lo_o == $past(dac_code[1:0])))
      else $error("lower pins not lower result bits");
   AST_HI_OE: assert property (
      $stable(upper_byte_output_enable_n) [*4]
      |-> (data_hi_oe == !upper_byte_output_enable_n))
      else $error("upper buffer enable wrong");
   AST_LO_OE: assert property (
      $stable(lower_byte_output_enable_n) [*4]
      |-> (data_lo_oe == !lower_byte_output_enable_n))
      else $error("lower buffer enable wrong");
   AST_OFFSET: assert property (
      $stable(range_unipolar) [*8] |-> (offset_inject == !range_unipolar))
      else $error("offset switch disagrees with range pin");
endmodule : sac_adc_ctrl_props

bind sac_adc_ctrl sac_adc_ctrl_props #(.W(W), .STEP_CYC(STEP_CYC)) u_props (
   .ref_clk(ref_clk),
   .nrst(nrst),
   .convert(convert),
   .range_unipolar(range_unipolar),
   .upper_byte_output_enable_n(upper_byte_output_enable_n),
   .lower_byte_output_enable_n(lower_byte_output_enable_n),
   .conversion_done_n(conversion_done_n),
   .data_hi_o(data_hi_o),
   .data_hi_oe(data_hi_oe),
   .data_lo_o(data_lo_o),
   .data_lo_oe(data_lo_oe),
   .dac_code(dac_code),
   .offset_inject(offset_inject)
);

// file: test/sac_afe_model.sv
// behavioural comparator and offset network facing the controller
`timescale 1ns/1ns

module sac_afe_model (
   // from the controller
   input wire logic [9:0] dac_code,
   input wire logic offset_inject,
   // analog input, in lsb steps, signed
   input wire logic signed [11:0] ain,
   // to the controller
   output logic comp_gt
);
   // =================================================================
   // comparator; answers at once, the controller syncs it anyway
   // sum versus offset input
   assign comp_gt = $signed({2'b00, dac_code}) >
      (ain + (offset_inject ? 12'sh200 : 12'sh000));
endmodule : sac_afe_model

// file: test/sac_adc_ctrl_tb.sv
// self-checking bench for the conversion controller
`timescale 1ns/1ns
`include "sac_params.svh"

module sac_adc_ctrl_tb;
   // =================================================================
   // stimulus and observed signals
   logic ref_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [`SAC_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdata;
   logic pready, pslverr, rerr, comp_gt, offset_inject, irq;
   logic convert = 1'b0, range_unipolar = 1'b1;
   logic upper_n = 1'b1, lower_n = 1'b1, conversion_done_n;
   logic [7:0] data_hi_o;
   logic [1:0] data_lo_o;
   logic data_hi_oe, data_lo_oe;
   logic [9:0] dac_code;
   logic signed [11:0] ain = '0;
   int n_errors = 0, tests_run = 0;
   // conversion table: range pin, input, expected code
   logic tr [8] = '{1, 1, 1, 1, 1, 0, 0, 0};
   logic signed [11:0] tv [8] = '{12'sh000, 12'sh001, 12'sh155,
      12'sh2AA, 12'sh3FF, -12'sh200, 12'sh000, 12'sh1FF};
   logic [9:0] te [8] = '{10'h000, 10'h001, 10'h155, 10'h2AA,
      10'h3FF, 10'h000, 10'h200, 10'h3FF};

   // short step counts keep each conversion to a few dozen cycles
   sac_adc_ctrl #(.STEP_CYC(4), .CS_CYC(3)) dut_u (
      .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .convert(convert),
      .range_unipolar(range_unipolar),
      .upper_byte_output_enable_n(upper_n),
      .lower_byte_output_enable_n(lower_n),
      .conversion_done_n(conversion_done_n), .data_hi_o(data_hi_o),
      .data_hi_oe(data_hi_oe), .data_lo_o(data_lo_o),
      .data_lo_oe(data_lo_oe), .comp_gt(comp_gt), .dac_code(dac_code),
      .offset_inject(offset_inject), .irq(irq));
   sac_afe_model afe_u (.dac_code(dac_code),
      .offset_inject(offset_inject), .ain(ain), .comp_gt(comp_gt));

   // =================================================================
   // clock, 4 ns period
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end

   // =================================================================
   // helpers
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            exp);
         n_errors++;
      end
   endtask : check

   // one apb transfer; values read right after an edge are pre-edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // no cycle count assumed; the watchdog ends a hung wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdata, exp);
   endtask : rd

   // a software start raises the done line a few edges late: wait for it
   task wait_done;
      while (conversion_done_n !== 1'b1) begin
         @(posedge ref_clk);
      end
      do begin
         @(posedge ref_clk);
      end while (conversion_done_n !== 1'b0);
   endtask : wait_done

   // start pulse of 500 ns, then run, then read via pins and register
   task conv(input logic signed [11:0] v, input logic [9:0] exp);
      ain <= v;
      convert <= 1'b1;
      repeat (125) @(posedge ref_clk);
      check(conversion_done_n, 1'b1);
      check(dac_code, 10'h000);
      convert <= 1'b0;
      wait_done;
      rd(`SAC_ADDR_RESULT, {22'h0, exp});
      upper_n <= 1'b0;
      lower_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      check({data_hi_oe, data_lo_oe, data_hi_o, data_lo_o},
         {2'b11, exp});
      upper_n <= 1'b1;
      lower_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      check({data_hi_oe, data_lo_oe}, 2'b00);
   endtask : conv

   task summarize;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   // =================================================================
   // watchdog, well beyond the cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      $display("unexpected at %0t: seen %h expected %h", $time, 0, 1);
      n_errors++;
      summarize;
   end

   // =================================================================
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(`SAC_ADDR_STATUS, 32'h4);
      rd(`SAC_ADDR_INT_MASK, 32'h0);
      rd(12'h020, 32'h0);
      check(rerr, 1'b1);
      apb(1'b1, `SAC_ADDR_INT_MASK, 32'h1);
      for (int i = 0; i < 8; i++) begin
         range_unipolar <= tr[i];
         repeat (10) @(posedge ref_clk);
         check(offset_inject, !tr[i]);
         if (i == 5) begin
            rd(`SAC_ADDR_STATUS, 32'h2);
         end
         conv(tv[i], te[i]);
         if (i == 0) begin
            check(irq, 1'b1);
            rd(`SAC_ADDR_INT_STAT, 32'h1);
            apb(1'b1, `SAC_ADDR_INT_STAT, 32'h1);
            repeat (3) @(posedge ref_clk);
            check(irq, 1'b0);
            apb(1'b1, `SAC_ADDR_INT_MASK, 32'h0);
         end
      end
      // partial data mid run, then a restart aborts it
      convert <= 1'b1;
      repeat (125) @(posedge ref_clk);
      convert <= 1'b0;
      repeat (16) @(posedge ref_clk);
      upper_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      check({data_hi_oe, conversion_done_n}, 2'b11);
      upper_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      conv(12'sh000, 10'h200);
      check(irq, 1'b0);
      rd(`SAC_ADDR_INT_STAT, 32'h3);
      apb(1'b1, `SAC_ADDR_INT_STAT, 32'h3);
      rd(`SAC_ADDR_INT_STAT, 32'h0);
      // software start through the control register
      ain <= -12'sh200;
      apb(1'b1, `SAC_ADDR_CTRL, 32'h1);
      wait_done;
      rd(`SAC_ADDR_RESULT, 32'h0);
      ain <= 12'sh1FF;
      apb(1'b1, `SAC_ADDR_CTRL, 32'h1);
      repeat (`SAC_T_CONV_MAX_NS * `SAC_CLK_MHZ / 1000) @(posedge ref_clk);
      rd(`SAC_ADDR_RESULT, 32'h3FF);
      summarize;
   end
endmodule : sac_adc_ctrl_tb
